// ===== design/lpmc_regs.svh
// Purpose: register map and mode encodings of the low power mode controller
// Assumes: plain register port, 32-bit words, byte offsets
// Notes: field positions and codes named here, types in lpmc_pkg
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
`define LPMC_ADDR_W        4
`define LPMC_OFF_MODE_SEL  4'h0
`define LPMC_OFF_CTRL      4'h4
`define LPMC_OFF_PERI_KEEP 4'h8
`define LPMC_OFF_WAKE_EN   4'hC
`define LPMC_MODE_W        4
`define LPMC_PERI_W        8
`define LPMC_CTRL_SUBOFF   0
`define LPMC_CTRL_SUBRUN   1
`define LPMC_CTRL_LVSUB    2
`define LPMC_CTRL_W        3
`define LPMC_RST_CTRL      3'h0
`define LPMC_RST_MODE      4'h0
`define LPMC_RST_PERI      8'h00
`define LPMC_RST_WAKE      8'h00
`define LPMC_SEL_HALT      4'h1
`define LPMC_SEL_STANDBY_FLASH_ON     4'h2
`define LPMC_SEL_STANDBY_FLASH_OFF     4'h3
`define LPMC_SEL_STOP      4'h4
`define LPMC_SEL_LVSTOP    4'h5
`define LPMC_SEL_SUBIDLE   4'h6
`define LPMC_SEL_LVSUBIDLE 4'h7
`define LPMC_SEL_RTCBK     4'h8
`define LPMC_TIMER_WAKE    0
`endif

// ===== design/lpmc_pkg.sv
// Purpose: types of the low power mode controller
// Assumes: included after lpmc_regs.svh
// Notes: state codes are the registered mode state
package lpmc_pkg;
	typedef enum logic [3:0] {
		LPMC_RUN       = 4'b0000,
		LPMC_HALT      = 4'b0001,
		LPMC_STANDBY_FLASH_ON     = 4'b0010,
		LPMC_STANDBY_FLASH_OFF     = 4'b0011,
		LPMC_STOP      = 4'b0100,
		LPMC_LVSTOP    = 4'b0101,
		LPMC_SUBIDLE   = 4'b0110,
		LPMC_LVSUBIDLE = 4'b0111,
		LPMC_RTCBK     = 4'b1000,
		LPMC_SUBRUN    = 4'b1001,
		LPMC_LVSUBRUN  = 4'b1010
	} lpmc_state_t;
endpackage : lpmc_pkg

// ===== design/lpmc_ctrl.sv
// Purpose: standby and low power mode controller, clock gates and power enables
// Assumes: standby request and wake lines are asynchronous to ref_clk
// Notes: every clock and power output is a flip-flop decoded from the next mode state
`include "lpmc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl
	import lpmc_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	input  wire logic [`LPMC_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata,
	input  wire logic                    standby_req,
	input  wire logic [7:0]              wake_irq,
	output logic                         cpu_clk_en,
	output logic      [`LPMC_PERI_W-1:0] peri_clk_en,
	output logic                         main_osc_en,
	output logic                         pll_en,
	output logic                         standby_flash_on,
	output logic                         sub_osc_en,
	output logic                         sys_clk_sel_sub,
	output logic                         reg_low_voltage,
	output logic                         ram_retain,
	output logic                         rtc_clk_en,
	output logic                         rtc_backup_supply,
	output logic      [3:0]              mode_state
);
	logic [`LPMC_MODE_W-1:0] mode_sel_reg;
	logic [`LPMC_CTRL_W-1:0] ctrl_reg;
	logic [`LPMC_PERI_W-1:0] peri_keep_reg;
	logic [7:0]              wake_en_reg;
	lpmc_state_t             state_reg;
	lpmc_state_t             state_next;
	logic                    req_s1_reg;
	logic                    req_s2_reg;
	logic                    req_d_reg;
	logic [7:0]              wake_s1_reg;
	logic [7:0]              wake_s2_reg;

	// pins from other domains pass two flops before use
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_s1_reg  <= 1'b0;
			req_s2_reg  <= 1'b0;
			req_d_reg   <= 1'b0;
			wake_s1_reg <= 8'h00;
			wake_s2_reg <= 8'h00;
		end else begin
			req_s1_reg  <= standby_req;
			req_s2_reg  <= req_s1_reg;
			req_d_reg   <= req_s2_reg;
			wake_s1_reg <= wake_irq;
			wake_s2_reg <= wake_s1_reg;
		end
	end

	wire req_rise   = req_s2_reg & ~req_d_reg;
	wire wake_any   = |(wake_s2_reg & wake_en_reg);
	wire timer_wake = wake_s2_reg[`LPMC_TIMER_WAKE];
	wire sel_wr     = reg_wr & (reg_addr == `LPMC_OFF_MODE_SEL);
	wire ctl_wr     = reg_wr & (reg_addr == `LPMC_OFF_CTRL);
	wire peri_wr    = reg_wr & (reg_addr == `LPMC_OFF_PERI_KEEP);
	wire wen_wr     = reg_wr & (reg_addr == `LPMC_OFF_WAKE_EN);
	wire in_run     = (state_reg == LPMC_RUN) | (state_reg == LPMC_SUBRUN) |
	                  (state_reg == LPMC_LVSUBRUN);
	wire lv_sub     = ctrl_reg[`LPMC_CTRL_LVSUB];
	wire sub_run    = ctrl_reg[`LPMC_CTRL_SUBRUN];
	wire sub_off    = ctrl_reg[`LPMC_CTRL_SUBOFF];
	// run state follows the software clock choice; standby returns here
	wire lpmc_state_t run_target = !sub_run ? LPMC_RUN : (lv_sub ? LPMC_LVSUBRUN : LPMC_SUBRUN);

	lpmc_state_t sel_state;
	always_comb begin
		case (mode_sel_reg)
			`LPMC_SEL_HALT:      sel_state = LPMC_HALT;
			`LPMC_SEL_STANDBY_FLASH_ON:     sel_state = LPMC_STANDBY_FLASH_ON;
			`LPMC_SEL_STANDBY_FLASH_OFF:     sel_state = LPMC_STANDBY_FLASH_OFF;
			`LPMC_SEL_STOP:      sel_state = LPMC_STOP;
			`LPMC_SEL_LVSTOP:    sel_state = LPMC_LVSTOP;
			`LPMC_SEL_SUBIDLE:   sel_state = LPMC_SUBIDLE;
			`LPMC_SEL_LVSUBIDLE: sel_state = LPMC_LVSUBIDLE;
			`LPMC_SEL_RTCBK:     sel_state = LPMC_RTCBK;
			default:             sel_state = run_target;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LPMC_RUN, LPMC_SUBRUN, LPMC_LVSUBRUN: begin
				if (req_rise)
					state_next = sel_state;
				else
					state_next = run_target;
			end
			LPMC_HALT: begin
				if (wake_any | timer_wake)
					state_next = run_target;
			end
			LPMC_RTCBK: begin
				// only a reset leaves backup; ram content is not promised
				state_next = LPMC_RTCBK;
			end
			LPMC_STANDBY_FLASH_ON, LPMC_STANDBY_FLASH_OFF, LPMC_STOP, LPMC_LVSTOP, LPMC_SUBIDLE, LPMC_LVSUBIDLE: begin
				if (wake_any)
					state_next = run_target;
			end
			default: state_next = LPMC_RUN;
		endcase
	end

	// output decode from the next state so every output is one flop
	logic                    o_cpu;
	logic [`LPMC_PERI_W-1:0] o_peri;
	logic                    o_main;
	logic                    o_pll;
	logic                    o_flash;
	logic                    o_sub;
	logic                    o_sel_sub;
	logic                    o_lv;
	logic                    o_ram;
	logic                    o_rtc;
	logic                    o_bk;
	always_comb begin
		o_cpu     = 1'b0;
		o_peri    = {`LPMC_PERI_W{1'b0}};
		o_main    = 1'b1;
		o_pll     = 1'b1;
		o_flash   = 1'b1;
		o_sub     = 1'b1;
		o_sel_sub = 1'b0;
		o_lv      = 1'b0;
		o_ram     = 1'b1;
		o_rtc     = 1'b1;
		o_bk      = 1'b0;
		case (state_next)
			LPMC_RUN: begin
				o_cpu  = 1'b1;
				o_peri = {`LPMC_PERI_W{1'b1}};
			end
			LPMC_SUBRUN, LPMC_LVSUBRUN: begin
				o_cpu     = 1'b1;
				o_peri    = {`LPMC_PERI_W{1'b1}};
				o_sel_sub = 1'b1;
				o_lv      = (state_next == LPMC_LVSUBRUN);
			end
			LPMC_HALT: begin
				o_peri = {`LPMC_PERI_W{1'b1}};
			end
			LPMC_STANDBY_FLASH_ON: begin
				o_peri = peri_keep_reg;
			end
			LPMC_STANDBY_FLASH_OFF: begin
				o_pll   = 1'b0;
				o_flash = 1'b0;
			end
			LPMC_STOP, LPMC_LVSTOP: begin
				o_main  = 1'b0;
				o_pll   = 1'b0;
				o_flash = 1'b0;
				o_sub   = ~sub_off;
				o_rtc   = ~sub_off;
				o_ram   = 1'b1;
				o_lv    = (state_next == LPMC_LVSTOP);
			end
			LPMC_SUBIDLE: begin
				o_sel_sub = 1'b1;
			end
			LPMC_LVSUBIDLE: begin
				o_sel_sub = 1'b1;
				o_main    = 1'b0;
				o_pll     = 1'b0;
				o_flash   = 1'b0;
				o_lv      = 1'b1;
			end
			LPMC_RTCBK: begin
				o_main  = 1'b0;
				o_pll   = 1'b0;
				o_flash = 1'b0;
				o_ram   = 1'b0;
				o_bk    = 1'b1;
			end
			default: o_cpu = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg         <= LPMC_RUN;
			cpu_clk_en        <= 1'b1;
			peri_clk_en       <= {`LPMC_PERI_W{1'b1}};
			main_osc_en       <= 1'b1;
			pll_en            <= 1'b1;
			standby_flash_on  <= 1'b1;
			sub_osc_en        <= 1'b1;
			sys_clk_sel_sub   <= 1'b0;
			reg_low_voltage   <= 1'b0;
			ram_retain        <= 1'b1;
			rtc_clk_en        <= 1'b1;
			rtc_backup_supply <= 1'b0;
			mode_state        <= 4'h0;
		end else begin
			state_reg         <= state_next;
			cpu_clk_en        <= o_cpu;
			peri_clk_en       <= o_peri;
			main_osc_en       <= o_main;
			pll_en            <= o_pll;
			standby_flash_on  <= o_flash;
			sub_osc_en        <= o_sub;
			sys_clk_sel_sub   <= o_sel_sub;
			reg_low_voltage   <= o_lv;
			ram_retain        <= o_ram;
			rtc_clk_en        <= o_rtc;
			rtc_backup_supply <= o_bk;
			mode_state        <= state_next;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_sel_reg  <= `LPMC_RST_MODE;
			ctrl_reg      <= `LPMC_RST_CTRL;
			peri_keep_reg <= `LPMC_RST_PERI;
			wake_en_reg   <= `LPMC_RST_WAKE;
		end else begin
			if (sel_wr)
				mode_sel_reg <= reg_wdata[`LPMC_MODE_W-1:0];
			if (ctl_wr)
				ctrl_reg <= reg_wdata[`LPMC_CTRL_W-1:0];
			if (peri_wr)
				peri_keep_reg <= reg_wdata[`LPMC_PERI_W-1:0];
			if (wen_wr)
				wake_en_reg <= reg_wdata[7:0];
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			`LPMC_OFF_MODE_SEL:  rd_mux = {24'h0000_00, state_reg, mode_sel_reg};
			`LPMC_OFF_CTRL:      rd_mux = {29'h0000_0000, ctrl_reg};
			`LPMC_OFF_PERI_KEEP: rd_mux = {24'h0000_00, peri_keep_reg};
			`LPMC_OFF_WAKE_EN:   rd_mux = {24'h0000_00, wake_en_reg};
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	chk_halt_peri_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_HALT) |-> (!cpu_clk_en && peri_clk_en == {`LPMC_PERI_W{1'b1}}))
		else $error("halt gated a peripheral or left cpu clock on");
	chk_standby_flash_on_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_STANDBY_FLASH_ON) |-> (main_osc_en && pll_en && standby_flash_on && peri_clk_en == peri_keep_reg))
		else $error("first idle level wrong enables");
	chk_standby_flash_off_flash: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_STANDBY_FLASH_OFF) |-> (main_osc_en && !pll_en && !standby_flash_on))
		else $error("second idle level wrong enables");
	chk_stop_subosc: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_STOP) |-> (!main_osc_en && sub_osc_en == !sub_off && ram_retain))
		else $error("stop mode oscillator or retention wrong");
	chk_lv_regulator: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_LVSTOP || state_reg == LPMC_LVSUBIDLE) |-> reg_low_voltage)
		else $error("low voltage mode without lowered regulator");
	chk_subrun_clk: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_SUBRUN) |-> (sys_clk_sel_sub && cpu_clk_en && !reg_low_voltage))
		else $error("sub clock run without sub clock select");
	chk_rtc_backup: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == LPMC_RTCBK) |-> (rtc_backup_supply && rtc_clk_en && !ram_retain && !main_osc_en))
		else $error("rtc backup enables wrong");
	sequence halted_timer;
		(state_reg == LPMC_HALT) && timer_wake;
	endsequence
	chk_halt_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
		halted_timer |=> (cpu_clk_en && state_reg != LPMC_HALT))
		else $error("timer interrupt did not release halt");
	chk_entry_req: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(in_run && !req_rise) |=> in_run)
		else $error("left run mode without standby request");
	chk_wake_return: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!in_run && state_reg != LPMC_RTCBK && wake_any) |=> (in_run && cpu_clk_en && main_osc_en))
		else $error("enabled wake did not restore run mode");
endmodule : lpmc_ctrl
`default_nettype wire

// ===== testbench/lpmc_cpu_model.sv
// Purpose: far side of the mode controller: cpu standby request and timer interrupt
// Assumes: bench pulses sleep_go for one cycle after an edge and holds wake_go levels
// Notes: timer answers slowly, only after the cpu clock has stayed gated a while
`timescale 1ns/1ps
`default_nettype none
module lpmc_cpu_model (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       sleep_go,
	input  wire logic [7:0] wake_go,
	input  wire logic       timer_arm,
	input  wire logic       cpu_clk_en,
	output logic            standby_req,
	output logic      [7:0] wake_irq
);
	logic [5:0] hold_cnt;
	logic [5:0] tick_cnt;
	// level held well past the two-flop sync of the controller
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) hold_cnt <= 6'h00;
		else if (sleep_go) hold_cnt <= 6'h08;
		else if (hold_cnt != 6'h00) hold_cnt <= hold_cnt - 6'h01;
	end
	assign standby_req = (hold_cnt != 6'h00);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) tick_cnt <= 6'h00;
		else if (cpu_clk_en || !timer_arm) tick_cnt <= 6'h00;
		else if (tick_cnt != 6'h18) tick_cnt <= tick_cnt + 6'h01;
	end
	assign wake_irq = wake_go | {7'h00, tick_cnt == 6'h18};
endmodule : lpmc_cpu_model
`default_nettype wire

// ===== testbench/test_low_power_mode_controller.sv
// Purpose: self-checking bench of the mode controller
// Assumes: wake enable 0x02, peripheral keep mask 0x5a
// Notes: only outputs the rules fix per mode are compared, others masked
`include "lpmc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_controller;
	import lpmc_pkg::*;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, sleep_go, timer_arm, sub_off;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [7:0]  wake_go;
	wire logic [31:0] reg_rdata;
	wire logic [7:0]  wake_irq, peri_clk_en;
	wire logic [3:0]  mode_state;
	wire logic        standby_req, cpu_clk_en, main_osc_en, pll_en, standby_flash_on, sub_osc_en;
	wire logic        sys_clk_sel_sub, reg_low_voltage, ram_retain, rtc_clk_en, rtc_backup_supply;
	wire logic [9:0]  obs;
	int n_errors;
	int tests_run;
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	lpmc_ctrl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req),
		.wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en), .peri_clk_en(peri_clk_en), .main_osc_en(main_osc_en),
		.pll_en(pll_en), .standby_flash_on(standby_flash_on), .sub_osc_en(sub_osc_en),
		.sys_clk_sel_sub(sys_clk_sel_sub), .reg_low_voltage(reg_low_voltage), .ram_retain(ram_retain),
		.rtc_clk_en(rtc_clk_en), .rtc_backup_supply(rtc_backup_supply), .mode_state(mode_state));
	lpmc_cpu_model far_side (.ref_clk(ref_clk), .sys_rst(sys_rst), .sleep_go(sleep_go), .wake_go(wake_go),
		.timer_arm(timer_arm), .cpu_clk_en(cpu_clk_en), .standby_req(standby_req), .wake_irq(wake_irq));
	assign obs = {cpu_clk_en, main_osc_en, pll_en, standby_flash_on, sub_osc_en, sys_clk_sel_sub,
		reg_low_voltage, ram_retain, rtc_clk_en, rtc_backup_supply};
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : check_word
	// sample off the edge so outputs launched there have settled
	task automatic check_outs(input logic [9:0] exp, input logic [9:0] mask);
		#1;
		tests_run++;
		if ((obs & mask) !== (exp & mask)) begin
			n_errors++;
			$display("Error at %0t: outputs %b, expected %b", $time, obs, exp & mask);
		end
		tick(1);
	endtask : check_outs
	// one idle edge after the strobe so a following write never re-drives it in the same step
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		#1;
		check_word(reg_rdata, exp);
		tick(1);
	endtask : reg_read
	task automatic wait_state(input logic [3:0] s);
		int i;
		#1;
		for (i = 0; i < 60 && mode_state !== s; i++) begin
			tick(1);
			#1;
		end
		check_word({28'h0, mode_state}, {28'h0, s});
		tick(1);
	endtask : wait_state
	function automatic logic [19:0] mode_exp(input logic [3:0] m);
		case (m)
			LPMC_HALT: return {10'h1e6, 10'h3ff};
			LPMC_STANDBY_FLASH_ON: return {10'h1c0, 10'h3c8};
			LPMC_STANDBY_FLASH_OFF: return {10'h100, 10'h3c0};
			LPMC_STOP: return sub_off ? {10'h004, 10'h3ee} : {10'h024, 10'h3ec};
			LPMC_LVSTOP: return {10'h02c, 10'h3ec};
			LPMC_SUBIDLE: return {10'h1c0, 10'h3c0};
			LPMC_LVSUBIDLE: return {10'h008, 10'h388};
			LPMC_RTCBK: return {10'h003, 10'h207};
			default: return {10'h3e6, 10'h3ff};
		endcase
	endfunction : mode_exp
	task automatic run_mode(input logic [3:0] m);
		logic [19:0] e;
		e = mode_exp(m);
		reg_write(`LPMC_OFF_MODE_SEL, {28'h0, m});
		reg_read(`LPMC_OFF_MODE_SEL, {28'h0, m});
		tick(6);
		check_word({28'h0, mode_state}, 32'h0000_0000);
		timer_arm <= (m == LPMC_HALT);
		sleep_go <= 1'b1;
		tick(1);
		sleep_go <= 1'b0;
		wait_state(m);
		check_outs(e[19:10], e[9:0]);
		if (m == LPMC_HALT) check_word({24'h0, peri_clk_en}, 32'h0000_00ff);
		if (m == LPMC_STANDBY_FLASH_ON) check_word({24'h0, peri_clk_en}, 32'h0000_005a);
		if (m != LPMC_HALT) begin
			wake_go <= 8'h04;
			tick(8);
			check_word({28'h0, mode_state}, {28'h0, m});
			wake_go <= 8'h02;
		end
		if (m != LPMC_RTCBK) begin
			wait_state(LPMC_RUN);
			wake_go <= 8'h00;
			tick(2);
			check_outs(10'h3e6, 10'h3ff);
		end
		$display("mode %0d test done", m);
	endtask : run_mode
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim();
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, sleep_go, timer_arm, sub_off} = 6'h01 << 5;
		{reg_addr, reg_wdata, wake_go} = '0;
		n_errors = 0;
		tests_run = 0;
		tick(16);
		sys_rst <= 1'b0;
		tick(1);
		check_outs(10'h3e6, 10'h3ff);
		reg_read(`LPMC_OFF_CTRL, 32'h0000_0000);
		reg_write(4'h2, 32'hffff_ffff);
		reg_read(4'h2, 32'h0000_0000);
		reg_write(`LPMC_OFF_PERI_KEEP, 32'h0000_005a);
		reg_write(`LPMC_OFF_WAKE_EN, 32'h0000_0002);
		reg_read(`LPMC_OFF_WAKE_EN, 32'h0000_0002);
		run_mode(LPMC_HALT);
		run_mode(LPMC_STANDBY_FLASH_ON);
		run_mode(LPMC_STANDBY_FLASH_OFF);
		run_mode(LPMC_STOP);
		run_mode(LPMC_LVSTOP);
		reg_write(`LPMC_OFF_CTRL, 32'h0000_0001);
		sub_off = 1'b1;
		run_mode(LPMC_STOP);
		sub_off = 1'b0;
		run_mode(LPMC_SUBIDLE);
		run_mode(LPMC_LVSUBIDLE);
		reg_write(`LPMC_OFF_CTRL, 32'h0000_0002);
		tick(8);
		check_outs(10'h010, 10'h018);
		check_word({28'h0, mode_state}, {28'h0, LPMC_SUBRUN});
		reg_write(`LPMC_OFF_CTRL, 32'h0000_0006);
		tick(8);
		check_outs(10'h018, 10'h018);
		reg_write(`LPMC_OFF_CTRL, 32'h0000_0000);
		tick(8);
		check_outs(10'h3e6, 10'h3ff);
		$display("sub clock test done");
		run_mode(LPMC_RTCBK);
		sys_rst <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		check_outs(10'h3e6, 10'h3ff);
		$display("reset exit test done");
		end_sim();
	end
endmodule : test_low_power_mode_controller
`default_nettype wire
